// [hdl/audio_dac_clock_and_status.v]
// Audio converter clock generation, sample FIFOs, status and interrupts
`timescale 1ns/1ps
`include "conv_consts.vh"

// Notes on behaviour
// - The sample counter and FIFO reads advance only on the converter clock enable.
// - The sample rate is an integer division of the converter clock.
// - The converter clock is divided down from the auxiliary clock.
// - The divide ratio comes from the seven-bit field at control bits 6:0.
// - One sample per channel is taken every 256 converter clocks.
// - Interrupt type bit 1 asks on FIFO empty, 0 asks on FIFO not full.
module audio_dac_clock_and_status #(
  parameter SAMPLE_W = 16,
  parameter FIFO_AW  = 2,
  parameter DIV_W    = 7
) (
  input  wire                clk_i,
  input  wire                rst_i,
  input  wire                aux_tick_i,
  // Wishbone classic slave
  input  wire                cyc_i,
  input  wire                stb_i,
  input  wire                we_i,
  input  wire [3:0]          adr_i,
  input  wire [3:0]          sel_i,
  input  wire [31:0]         dat_i,
  output reg  [31:0]         dat_o,
  output reg                 ack_o,
  // Sample writes from processor or DMA
  input  wire                left_wr_i,
  input  wire [SAMPLE_W-1:0] left_data_i,
  input  wire                right_wr_i,
  input  wire [SAMPLE_W-1:0] right_data_i,
  output wire                left_ready_o,
  output wire                right_ready_o,
  // Converter side
  output reg                 sample_tick_o,
  output wire [SAMPLE_W-1:0] left_sample_o,
  output wire [SAMPLE_W-1:0] right_sample_o,
  output reg                 left_out_enable_o,
  output reg                 right_out_enable_o,
  output reg                 left_mid_enable_o,
  output reg                 right_mid_enable_o,
  output wire                irq_o
);
  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  reg  [15:0]            converter_control;
  reg  [15:0]            status_ctl;
  reg  [1:0]             irq_status;
  reg  [1:0]             irq_mask;
  reg  [`OSR_WIDTH-1:0]  osr_count;
  wire                   conv_tick;
  wire                   left_full;
  wire                   left_empty;
  wire                   right_full;
  wire                   right_empty;
  wire [15:0]            converter_status;
  wire [1:0]             irq_event;
  wire                   bus_req;
  wire                   wr_en;
  wire                   sample_take;
  wire [DIV_W-1:0]       conv_clk_divisor;

  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_en   = bus_req && we_i;

  // Byte lane enable for a 16-bit register in the low half
  function [15:0] lane_mask;
    input [3:0] sel;
    begin
      lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
    end
  endfunction

  // -------------------------------------------------------------------
  // Clock derivation
  // -------------------------------------------------------------------
  assign conv_clk_divisor =
    converter_control[`CTL_DIV_HI:`CTL_DIV_LO];

  conv_clk_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .aux_tick_i  (aux_tick_i),
    .divisor_i   (conv_clk_divisor),
    .conv_tick_o (conv_tick)
  );

  // Sample rate is a fixed submultiple of the converter clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      osr_count     <= {`OSR_WIDTH{1'b0}};
      sample_tick_o <= 1'b0;
    end else begin
      sample_tick_o <= 1'b0;
      if (conv_tick) begin
        osr_count <= osr_count + {{(`OSR_WIDTH-1){1'b0}}, 1'b1};
        if (osr_count == `OSR_COUNT - 1)
          sample_tick_o <= 1'b1;
      end
    end
  end

  assign sample_take = conv_tick && (osr_count == `OSR_COUNT - 1);

  // -------------------------------------------------------------------
  // Sample FIFOs
  // -------------------------------------------------------------------
  conv_fifo #(
    .WIDTH (SAMPLE_W),
    .AW    (FIFO_AW)
  ) u_left (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (left_wr_i),
    .wdata_i (left_data_i),
    .rd_i    (sample_take),
    .rdata_o (left_sample_o),
    .full_o  (left_full),
    .empty_o (left_empty)
  );

  conv_fifo #(
    .WIDTH (SAMPLE_W),
    .AW    (FIFO_AW)
  ) u_right (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (right_wr_i),
    .wdata_i (right_data_i),
    .rd_i    (sample_take),
    .rdata_o (right_sample_o),
    .full_o  (right_full),
    .empty_o (right_empty)
  );

  assign left_ready_o  = !left_full;
  assign right_ready_o = !right_full;

  // -------------------------------------------------------------------
  // Status register
  // -------------------------------------------------------------------
  assign converter_status =
    (status_ctl & `ST_WMASK)
    | ({15'h0000, left_full}   << `ST_LEFT_FULL)
    | ({15'h0000, left_empty}  << `ST_LEFT_EMPTY)
    | ({15'h0000, right_full}  << `ST_RIGHT_FULL)
    | ({15'h0000, right_empty} << `ST_RIGHT_EMPTY);

  always @(posedge clk_i) begin
    if (rst_i) begin
      left_out_enable_o  <= 1'b0;
      right_out_enable_o <= 1'b0;
      left_mid_enable_o  <= 1'b0;
      right_mid_enable_o <= 1'b0;
    end else begin
      left_out_enable_o  <= status_ctl[`ST_LEFT_OE];
      right_out_enable_o <= status_ctl[`ST_RIGHT_OE];
      left_mid_enable_o  <= status_ctl[`ST_LEFT_MID];
      right_mid_enable_o <= status_ctl[`ST_RIGHT_MID];
    end
  end

  // -------------------------------------------------------------------
  // Interrupts
  // -------------------------------------------------------------------
  // Level requests: empty when type is 1, not full when type is 0
  assign irq_event[`IRQ_LEFT] = status_ctl[`ST_LEFT_ITYPE]
    ? left_empty : !left_full;
  assign irq_event[`IRQ_RIGHT] = status_ctl[`ST_RIGHT_ITYPE]
    ? right_empty : !right_full;

  assign irq_o = |(irq_status & irq_mask);

  // -------------------------------------------------------------------
  // Bus writes
  // -------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      converter_control <= `CTL_RESET;
      status_ctl        <= `ST_RESET;
      irq_status        <= `IRQ_RESET;
      irq_mask          <= `IRQ_RESET;
    end else begin
      // Set wins over a write-one clear in the same cycle
      if (wr_en && adr_i == `ADDR_IRQ_STAT && sel_i[0])
        irq_status <= (irq_status & ~dat_i[1:0]) | irq_event;
      else
        irq_status <= irq_status | irq_event;
      if (wr_en && adr_i == `ADDR_CONTROL)
        converter_control <= (converter_control & ~lane_mask(sel_i))
          | (dat_i[15:0] & lane_mask(sel_i));
      if (wr_en && adr_i == `ADDR_STATUS)
        status_ctl <= (status_ctl & ~(lane_mask(sel_i) & `ST_WMASK))
          | (dat_i[15:0] & lane_mask(sel_i) & `ST_WMASK);
      if (wr_en && adr_i == `ADDR_IRQ_MASK && sel_i[0])
        irq_mask <= dat_i[1:0];
    end
  end

  // -------------------------------------------------------------------
  // Bus reads and acknowledge
  // -------------------------------------------------------------------
  // One wait state: ack a cycle after the request, drop it the next
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      if (bus_req && !we_i) begin
        case (adr_i)
          `ADDR_CONTROL:  dat_o <= {16'h0000, converter_control};
          `ADDR_STATUS:   dat_o <= {16'h0000, converter_status};
          `ADDR_IRQ_STAT: dat_o <= {30'h00000000, irq_status};
          `ADDR_IRQ_MASK: dat_o <= {30'h00000000, irq_mask};
          default:        dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// [hdl/conv_clk_div.v]
// Divider making the converter clock enable from the auxiliary clock
`timescale 1ns/1ps
module conv_clk_div #(
  parameter DIV_W = 7
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             aux_tick_i,
  input  wire [DIV_W-1:0] divisor_i,
  output reg              conv_tick_o
);
  reg [DIV_W-1:0] count;

  // Divides by divisor_i + 1, so a zero divisor passes every tick
  always @(posedge clk_i) begin
    if (rst_i) begin
      count       <= {DIV_W{1'b0}};
      conv_tick_o <= 1'b0;
    end else begin
      conv_tick_o <= 1'b0;
      if (aux_tick_i) begin
        if (count >= divisor_i) begin
          count       <= {DIV_W{1'b0}};
          conv_tick_o <= 1'b1;
        end else begin
          count <= count + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// [hdl/conv_consts.vh]
// Constants for the audio converter clock and status block
`ifndef CONV_CONSTS_VH
`define CONV_CONSTS_VH
// Register byte addresses
`define ADDR_CONTROL    4'h0
`define ADDR_STATUS     4'h4
`define ADDR_IRQ_STAT   4'h8
`define ADDR_IRQ_MASK   4'hC
// converter_control fields
`define CTL_DIV_HI      6
`define CTL_DIV_LO      0
`define CTL_RESET       16'h0000
`define DIV_RESET       7'h00
// converter_status fields
`define ST_LEFT_OE      15
`define ST_LEFT_MID     13
`define ST_LEFT_ITYPE   10
`define ST_LEFT_FULL    9
`define ST_LEFT_EMPTY   8
`define ST_RIGHT_OE     7
`define ST_RIGHT_MID    5
`define ST_RIGHT_ITYPE  2
`define ST_RIGHT_FULL   1
`define ST_RIGHT_EMPTY  0
`define ST_WMASK        16'hA4A4
`define ST_RESET        16'h0000
// Interrupt status bits
`define IRQ_LEFT        0
`define IRQ_RIGHT       1
`define IRQ_RESET       2'h0
// Converter clocks per sample period
`define OSR_COUNT       256
`define OSR_WIDTH       8
`endif

// [hdl/conv_fifo.v]
// Per-channel sample input FIFO
`timescale 1ns/1ps
module conv_fifo #(
  parameter WIDTH = 16,
  parameter AW    = 2
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             wr_i,
  input  wire [WIDTH-1:0] wdata_i,
  input  wire             rd_i,
  output reg  [WIDTH-1:0] rdata_o,
  output wire             full_o,
  output wire             empty_o
);
  localparam DEPTH = 1 << AW;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp;
  reg [AW:0]      rp;
  wire            do_wr;
  wire            do_rd;

  assign full_o  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty_o = (wp == rp);
  // Writes into a full FIFO are dropped; reads of an empty one hold data
  assign do_wr = wr_i && !full_o;
  assign do_rd = rd_i && !empty_o;

  always @(posedge clk_i) begin
    if (do_wr)
      mem[wp[AW-1:0]] <= wdata_i;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wp      <= {(AW+1){1'b0}};
      rp      <= {(AW+1){1'b0}};
      rdata_o <= {WIDTH{1'b0}};
    end else begin
      if (do_wr)
        wp <= wp + {{AW{1'b0}}, 1'b1};
      if (do_rd) begin
        rp      <= rp + {{AW{1'b0}}, 1'b1};
        rdata_o <= mem[rp[AW-1:0]];
      end
    end
  end
endmodule

// [verif/audio_dac_assertions.sv]
// Port-level assertions for the converter clock and status block
`timescale 1ns/1ps
module audio_dac_assertions #(
  parameter SAMPLE_W = 16
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                aux_tick_i,
  input wire logic                cyc_i,
  input wire logic                stb_i,
  input wire logic                we_i,
  input wire logic [3:0]          adr_i,
  input wire logic [3:0]          sel_i,
  input wire logic [31:0]         dat_i,
  input wire logic [31:0]         dat_o,
  input wire logic                ack_o,
  input wire logic                left_ready_o,
  input wire logic                sample_tick_o,
  input wire logic [SAMPLE_W-1:0] left_sample_o,
  input wire logic                left_out_enable_o,
  input wire logic                right_out_enable_o,
  input wire logic                left_mid_enable_o,
  input wire logic                right_mid_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        wr_st;
  logic [11:0] aux_cnt;
  assign wr_st = cyc_i && stb_i && !ack_o && we_i && adr_i == 4'h4;
  // An aux tick landing with the sample tick belongs to the next period
  always @(posedge clk_i)
    if (rst_i)
      aux_cnt <= 12'h000;
    else if (sample_tick_o)
      aux_cnt <= {11'h000, aux_tick_i};
    else if (aux_tick_i && aux_cnt != 12'hFFF)
      aux_cnt <= aux_cnt + 12'h001;
  property p_ack_once; ack_o |=> !ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_left_en; wr_st && sel_i[1] |-> ##2
    {left_out_enable_o, left_mid_enable_o} == $past({dat_i[15], dat_i[13]}, 2);
  endproperty
  a_left_en: assert property (p_left_en) else $error("left enables");
  property p_right_en; wr_st && sel_i[0] |-> ##2
    {right_out_enable_o, right_mid_enable_o} == $past({dat_i[7], dat_i[5]}, 2);
  endproperty
  a_right_en: assert property (p_right_en) else $error("right enables");
  property p_full_flag; ack_o && !we_i && adr_i == 4'h4 |->
    dat_o[9] == $past(!left_ready_o); endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag");
  property p_tick_gap; sample_tick_o |-> aux_cnt >= 12'd256; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("short period");
  property p_sample_hold; !sample_tick_o |-> $stable(left_sample_o);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("sample moved");
endmodule

bind audio_dac_clock_and_status audio_dac_assertions #(
  .SAMPLE_W(SAMPLE_W)
) audio_dac_assertions_inst (.clk_i, .rst_i, .aux_tick_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .left_ready_o,
  .sample_tick_o, .left_sample_o, .left_out_enable_o, .right_out_enable_o,
  .left_mid_enable_o, .right_mid_enable_o);

// [verif/audio_dac_clock_and_status_test.sv]
// Self-checking bench for the converter clock and status block
`timescale 1ns/1ps
`include "conv_consts.vh"
module audio_dac_clock_and_status_test;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             aux_tick_i = 1'b0;
  logic             aux_en = 1'b0;
  logic             cyc_i = 1'b0;
  logic             stb_i = 1'b0;
  logic             we_i = 1'b0;
  logic [3:0]       adr_i = 4'h0;
  logic [3:0]       sel_i = 4'hF;
  logic [31:0]      dat_i = 32'h0;
  logic [31:0]      dat_o, q;
  logic             ack_o, irq_o, sample_tick_o;
  logic [1:0]       wr, rdy;
  logic [1:0]       go = 2'b00;
  logic [1:0][2:0]  n = {3'h2, 3'h4};
  logic [1:0][15:0] data;
  logic [15:0]      ls, rs;
  logic [3:0]       en;
  int               error_cnt = 0;
  int               n_checks = 0;
  int               per;
  audio_dac_clock_and_status audio_dac_clock_and_status_inst (
    .clk_i, .rst_i, .aux_tick_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .left_wr_i(wr[0]), .left_data_i(data[0]),
    .right_wr_i(wr[1]), .right_data_i(data[1]), .left_ready_o(rdy[0]),
    .right_ready_o(rdy[1]), .sample_tick_o, .left_sample_o(ls),
    .right_sample_o(rs), .left_out_enable_o(en[3]),
    .right_out_enable_o(en[2]), .left_mid_enable_o(en[1]),
    .right_mid_enable_o(en[0]), .irq_o);
  sample_feeder sample_feeder_inst (.clk_i, .rst_i, .go_i(go), .n_i(n),
    .ready_i(rdy), .wr_o(wr), .data_o(data));
  initial forever #5 clk_i = ~clk_i;
  // Aux clock at half the system rate
  always @(posedge clk_i) aux_tick_i <= aux_en & ~aux_tick_i;
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(string s, logic [3:0] a, logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  task automatic tick;
    per = 0;
    do begin
      @(negedge clk_i);
      per++;
    end while (sample_tick_o !== 1'b1);
    @(posedge clk_i);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("control", `ADDR_CONTROL, 32'h0);
    rd("status", `ADDR_STATUS, 32'h0101);
    wb(1'b1, 4'h2, 32'hFFFF);
    rd("unmapped", 4'h2, 32'h0);
    rd("irq status", `ADDR_IRQ_STAT, 32'h3);
    chk("irq_o", 32'h0, irq_o);
    wb(1'b1, `ADDR_STATUS, 32'hFFFF);
    rd("status rw", `ADDR_STATUS, 32'hA5A5);
    chk("enables", 32'hF, en);
    wb(1'b1, `ADDR_STATUS, 32'h0);
    chk("enables", 32'h0, en);
    $display("test reset and status done");
    go <= 2'b11;
    @(posedge clk_i);
    go <= 2'b00;
    while (rdy[0] !== 1'b0) @(posedge clk_i);
    @(posedge clk_i);
    rd("fifo flags", `ADDR_STATUS, 32'h0200);
    chk("left ready", 32'h0, rdy[0]);
    chk("right ready", 32'h1, rdy[1]);
    wb(1'b1, `ADDR_IRQ_MASK, 32'h1);
    chk("irq_o", 32'h1, irq_o);
    wb(1'b1, `ADDR_IRQ_STAT, 32'h3);
    rd("irq status", `ADDR_IRQ_STAT, 32'h2);
    chk("irq_o", 32'h0, irq_o);
    wb(1'b1, `ADDR_STATUS, 32'h0400);
    $display("test fifo and irq done");
    wb(1'b1, `ADDR_CONTROL, 32'h1);
    aux_en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      tick();
      if (k > 0) chk("period", 32'h400, per);
      chk("left sample", 32'h1000 + k, ls);
      chk("right sample", k ? 32'h1101 : 32'h1100, rs);
    end
    rd("irq status", `ADDR_IRQ_STAT, 32'h3);
    chk("irq_o", 32'h1, irq_o);
    wb(1'b1, `ADDR_CONTROL, 32'h3);
    tick();
    tick();
    chk("slow period", 32'h800, per);
    $display("test clock done");
    summarize();
  end
endmodule

// [verif/sample_feeder.sv]
// Processor or DMA model pushing sample words into both channel FIFOs
`timescale 1ns/1ps
module sample_feeder (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [1:0]      go_i,
  input  wire logic [1:0][2:0] n_i,
  input  wire logic [1:0]      ready_i,
  output logic      [1:0]      wr_o,
  output logic [1:0][15:0]     data_o
);
  logic [2:0]  cnt [2];
  logic [15:0] nxt [2];
  // Every other cycle only, so ready always reflects the last push
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        cnt[i] <= 3'h0;
        wr_o[i] <= 1'b0;
        nxt[i] <= i ? 16'h1100 : 16'h1000;
        data_o[i] <= 16'h0000;
      end else if (cnt[i] != 3'h0 && ready_i[i] && !wr_o[i]) begin
        wr_o[i] <= 1'b1;
        data_o[i] <= nxt[i];
        nxt[i] <= nxt[i] + 16'h0001;
        cnt[i] <= cnt[i] - 3'h1;
      end else begin
        wr_o[i] <= 1'b0;
        data_o[i] <= ~data_o[i];
        if (go_i[i])
          cnt[i] <= n_i[i];
      end
    end
  end
endmodule
